// file: logic/cmit_timer.v
`timescale 1ns/1ps
`include "cmit_consts.vh"

module cmit_timer (
  input wire clk_in,
  input wire nrst_in,
  input wire [`CMIT_ADDR_W-1:0] addr_in,
  input wire [`CMIT_DATA_W-1:0] wdata_in,
  input wire [1:0] byte_en_in,
  input wire wr_in,
  input wire rd_in,
  output reg [`CMIT_DATA_W-1:0] rdata_out,
  output wire [1:0] match_irq_request_out,
  output wire irq_out
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function tap_select;
    input [1:0] cks;
    input [3:0] ticks;
    begin
      case (cks)
        `CMIT_CKS_DIV8: tap_select = ticks[0];
        `CMIT_CKS_DIV32: tap_select = ticks[1];
        `CMIT_CKS_DIV128: tap_select = ticks[2];
        `CMIT_CKS_DIV512: tap_select = ticks[3];
        default: tap_select = 1'b0;
      endcase
    end
  endfunction

  // byte-lane merge: an unwritten lane keeps its old contents
  function [15:0] lane_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] be;
    begin
      lane_merge[15:8] = be[1] ? new_val[15:8] : old_val[15:8];
      lane_merge[7:0] = be[0] ? new_val[7:0] : old_val[7:0];
    end
  endfunction

  function [7:0] chan_off;
    input ch;
    input [7:0] off0;
    input [7:0] off1;
    begin
      chan_off = ch ? off1 : off0;
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [1:0] run_bits;
  reg [31:0] cnt;
  reg [31:0] cor;
  reg [3:0] cks;
  reg [1:0] irq_en;
  reg [1:0] flag;
  reg [1:0] clr_armed;
  reg [1:0] wrote_stopped;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;

  reg [31:0] next_cnt;
  reg [31:0] next_cor;
  reg [1:0] next_flag;
  reg [1:0] next_armed;
  reg [1:0] next_wrote;
  reg [1:0] match;
  reg [1:0] sel_csr;
  reg [1:0] sel_cnt;
  reg [1:0] sel_cor;
  reg [`CMIT_DATA_W-1:0] next_rdata;

  wire [3:0] ticks;
  wire sel_run;
  wire sel_ist;
  wire sel_imsk;

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  cmit_prescaler #(
    .DIV_W(`CMIT_DIV512_LOG2)
  ) u_prescaler (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .tick_out(ticks)
  );

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign sel_run = (addr_in == `CMIT_OFF_RUN);
  assign sel_ist = (addr_in == `CMIT_OFF_IST);
  assign sel_imsk = (addr_in == `CMIT_OFF_IMSK);

  always @* begin : decode
    integer i;
    sel_csr = 2'h0;
    sel_cnt = 2'h0;
    sel_cor = 2'h0;
    for (i = 0; i < `CMIT_CHANNELS; i = i + 1) begin
      sel_csr[i] = (addr_in == chan_off(i[0], `CMIT_OFF_CSR0, `CMIT_OFF_CSR1));
      sel_cnt[i] = (addr_in == chan_off(i[0], `CMIT_OFF_CNT0, `CMIT_OFF_CNT1));
      sel_cor[i] = (addr_in == chan_off(i[0], `CMIT_OFF_COR0, `CMIT_OFF_COR1));
    end
  end

  // ----------------------------------------
  // counter, constant and flag next values
  // ----------------------------------------
  // priority per channel: match clear, then bus write, then count-up
  always @* begin : channel_next
    integer i;
    reg tick;
    reg hit;
    reg clr_req;
    reg [15:0] c;
    reg [15:0] k;
    tick = 1'b0;
    hit = 1'b0;
    clr_req = 1'b0;
    c = 16'h0000;
    k = 16'h0000;
    next_cnt = cnt;
    next_cor = cor;
    next_flag = flag;
    next_armed = clr_armed;
    next_wrote = 2'h0;
    match = 2'h0;
    for (i = 0; i < `CMIT_CHANNELS; i = i + 1) begin
      c = cnt[i*16 +: 16];
      k = cor[i*16 +: 16];
      tick = run_bits[i] & tap_select(cks[i*2 +: 2], ticks);
      hit = (c == k);
      // while running, equality waits for the next tick; a stopped channel matches in the cycle after a counter or constant write
      match[i] = (tick & hit) | (~run_bits[i] & wrote_stopped[i] & hit);
      if (match[i]) begin
        next_cnt[i*16 +: 16] = `CMIT_RST_CNT;
      end else if (wr_in & sel_cnt[i]) begin
        next_cnt[i*16 +: 16] = lane_merge(c, wdata_in, byte_en_in);
      end else if (tick) begin
        next_cnt[i*16 +: 16] = c + 16'h0001;
      end
      if (wr_in & sel_cor[i]) begin
        next_cor[i*16 +: 16] = lane_merge(k, wdata_in, byte_en_in);
      end
      // a stopped channel is rechecked once after each counter or constant write
      next_wrote[i] = wr_in & (sel_cnt[i] | sel_cor[i]) & ~run_bits[i];
      // a write of one to the flag bit never sets it
      clr_req = wr_in & sel_csr[i] & byte_en_in[0] & ~wdata_in[`CMIT_CSR_FLAG]
        & clr_armed[i];
      // a new match in the clearing cycle wins so no event is lost
      next_flag[i] = match[i] | (flag[i] & ~clr_req);
      if (wr_in & sel_csr[i] & byte_en_in[0]) begin
        next_armed[i] = 1'b0;
      end else if (rd_in & sel_csr[i] & flag[i]) begin
        next_armed[i] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_bits <= `CMIT_RST_RUN;
      cnt <= {`CMIT_RST_CNT, `CMIT_RST_CNT};
      cor <= {`CMIT_RST_COR, `CMIT_RST_COR};
      flag <= 2'h0;
      clr_armed <= 2'h0;
      wrote_stopped <= 2'h0;
    end else begin
      cnt <= next_cnt;
      cor <= next_cor;
      flag <= next_flag;
      clr_armed <= next_armed;
      wrote_stopped <= next_wrote;
      if (wr_in & sel_run & byte_en_in[0]) begin
        run_bits <= wdata_in[1:0];
      end
    end
  end

  // reset values of control fields
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cks <= {`CMIT_RST_CKS, `CMIT_RST_CKS};
      irq_en <= 2'h0;
    end else begin
      if (wr_in & sel_csr[0] & byte_en_in[0]) begin
        cks[1:0] <= wdata_in[`CMIT_CSR_CKS_HI:`CMIT_CSR_CKS_LO];
        irq_en[0] <= wdata_in[`CMIT_CSR_IE];
      end
      if (wr_in & sel_csr[1] & byte_en_in[0]) begin
        cks[3:2] <= wdata_in[`CMIT_CSR_CKS_HI:`CMIT_CSR_CKS_LO];
        irq_en[1] <= wdata_in[`CMIT_CSR_IE];
      end
    end
  end

  // ----------------------------------------
  // interrupt summary
  // ----------------------------------------
  // sticky status is separate from the flag so a polled flag clear
  // does not hide an event from the summary line
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      if (wr_in & sel_ist & byte_en_in[0]) begin
        irq_status <= match | (irq_status & ~wdata_in[1:0]);
      end else begin
        irq_status <= irq_status | match;
      end
      if (wr_in & sel_imsk & byte_en_in[0]) begin
        irq_mask <= wdata_in[1:0];
      end
    end
  end

  assign match_irq_request_out = flag & irq_en;
  assign irq_out = |(irq_status & irq_mask);

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always @* begin
    next_rdata = 16'h0000;
    if (sel_run) begin
      next_rdata[1:0] = run_bits;
    end else if (sel_csr[0]) begin
      next_rdata[`CMIT_CSR_FLAG] = flag[0];
      next_rdata[`CMIT_CSR_IE] = irq_en[0];
      next_rdata[1:0] = cks[1:0];
    end else if (sel_csr[1]) begin
      next_rdata[`CMIT_CSR_FLAG] = flag[1];
      next_rdata[`CMIT_CSR_IE] = irq_en[1];
      next_rdata[1:0] = cks[3:2];
    end else if (sel_cnt[0]) begin
      next_rdata = cnt[15:0];
    end else if (sel_cnt[1]) begin
      next_rdata = cnt[31:16];
    end else if (sel_cor[0]) begin
      next_rdata = cor[15:0];
    end else if (sel_cor[1]) begin
      next_rdata = cor[31:16];
    end else if (sel_ist) begin
      next_rdata[1:0] = irq_status;
    end else if (sel_imsk) begin
      next_rdata[1:0] = irq_mask;
    end
  end

  // data stand only in the cycle after the strobe; unmapped reads give zero
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= 16'h0000;
    end
  end

endmodule

// file: logic/cmit_consts.vh
`ifndef CMIT_CONSTS_VH
`define CMIT_CONSTS_VH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define CMIT_ADDR_W 8
`define CMIT_DATA_W 16
`define CMIT_CHANNELS 2

// ----------------------------------------
// register offsets (byte addresses, 16-bit registers)
// ----------------------------------------
`define CMIT_OFF_RUN 8'h00
`define CMIT_OFF_CSR0 8'h02
`define CMIT_OFF_CNT0 8'h04
`define CMIT_OFF_COR0 8'h06
`define CMIT_OFF_CSR1 8'h08
`define CMIT_OFF_CNT1 8'h0A
`define CMIT_OFF_COR1 8'h0C
`define CMIT_OFF_IST 8'h10
`define CMIT_OFF_IMSK 8'h12

// ----------------------------------------
// field positions
// ----------------------------------------
`define CMIT_CSR_FLAG 7
`define CMIT_CSR_IE 6
`define CMIT_CSR_CKS_HI 1
`define CMIT_CSR_CKS_LO 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CMIT_RST_RUN 2'h0
`define CMIT_RST_CNT 16'h0000
`define CMIT_RST_COR 16'hFFFF
`define CMIT_RST_CKS 2'h0

// ----------------------------------------
// clock-select codes and prescaler taps (log2 of divisor)
// ----------------------------------------
`define CMIT_CKS_DIV8 2'h0
`define CMIT_CKS_DIV32 2'h1
`define CMIT_CKS_DIV128 2'h2
`define CMIT_CKS_DIV512 2'h3
`define CMIT_DIV8_LOG2 3
`define CMIT_DIV32_LOG2 5
`define CMIT_DIV128_LOG2 7
`define CMIT_DIV512_LOG2 9

`endif

// file: logic/cmit_prescaler.v
`timescale 1ns/1ps
`include "cmit_consts.vh"

// ----------------------------------------
// free-running divider, one-cycle tick per tap
// ----------------------------------------
module cmit_prescaler #(
  parameter DIV_W = `CMIT_DIV512_LOG2
) (
  input wire clk_in,
  input wire nrst_in,
  output wire [3:0] tick_out
);

  reg [DIV_W-1:0] div;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div <= {DIV_W{1'b0}};
    end else begin
      div <= div + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // tick when the low bits roll over, so every tap is a single-cycle enable
  assign tick_out[0] = &div[`CMIT_DIV8_LOG2-1:0];
  assign tick_out[1] = &div[`CMIT_DIV32_LOG2-1:0];
  assign tick_out[2] = &div[`CMIT_DIV128_LOG2-1:0];
  assign tick_out[3] = &div[`CMIT_DIV512_LOG2-1:0];

endmodule

// file: verification/cmit_timer_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checks
// ----------------------------------------
module cmit_timer_props (
  input wire clk_in,
  input wire nrst_in,
  input wire [7:0] addr_in,
  input wire [15:0] wdata_in,
  input wire [1:0] byte_en_in,
  input wire wr_in,
  input wire rd_in,
  input wire [15:0] rdata_out,
  input wire [1:0] match_irq_request_out,
  input wire irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence wr_at(a);
    wr_in && addr_in == a && byte_en_in == 2'h3;
  endsequence
  sequence rd_at(a);
    rd_in && addr_in == a;
  endsequence
  // write then read at once: hardware must not have touched these fields
  property back(a, m);
    wr_at(a) ##1 rd_at(a) |=> (rdata_out & m) == ($past(wdata_in, 2) & m);
  endproperty
  chk_cor0_back: assert property (back(8'h06, 16'hFFFF))
    else $error("constant 0 readback wrong");
  chk_cor1_back: assert property (back(8'h0C, 16'hFFFF))
    else $error("constant 1 readback wrong");
  chk_run_back: assert property (back(8'h00, 16'h0003))
    else $error("run bits readback wrong");
  chk_csr_back: assert property (back(8'h08, 16'h0043))
    else $error("select field readback wrong");
  chk_req0_fall: assert property ($fell(match_irq_request_out[0]) |-> $past(wr_in))
    else $error("request 0 dropped without a write");
  chk_req1_fall: assert property ($fell(match_irq_request_out[1]) |-> $past(wr_in))
    else $error("request 1 dropped without a write");
  chk_flag_w1: assert property (match_irq_request_out[0] && wr_in && addr_in == 8'h02
    && byte_en_in[0] && wdata_in[7:6] == 2'h3 |=> match_irq_request_out[0])
    else $error("writing one cleared the flag");
  chk_irq_fall: assert property ($fell(irq_out) |-> $past(wr_in))
    else $error("interrupt dropped without a write");
endmodule

bind cmit_timer cmit_timer_props chk_u (.clk_in(clk_in), .nrst_in(nrst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .byte_en_in(byte_en_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .match_irq_request_out(match_irq_request_out),
  .irq_out(irq_out));

// file: verification/cmit_intc_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// interrupt controller stand-in
// ----------------------------------------
module cmit_intc_model (
  input wire clk_in,
  input wire nrst_in,
  input wire [1:0] req_in,
  output reg [7:0] rise0_out,
  output reg [7:0] rise1_out
);
  reg [1:0] last;
  // one vector per line, so a shared line would show up as a rise on both
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last <= 2'h0;
      rise0_out <= 8'h00;
      rise1_out <= 8'h00;
    end else begin
      last <= req_in;
      if (req_in[0] && !last[0]) begin
        rise0_out <= rise0_out + 8'h01;
      end
      if (req_in[1] && !last[1]) begin
        rise1_out <= rise1_out + 8'h01;
      end
    end
  end
endmodule

// file: verification/cmit_timer_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module cmit_timer_bench;
  reg clk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg [1:0] be = 2'h0;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  wire [15:0] rdata;
  wire [1:0] req;
  wire irq;
  wire [7:0] n0;
  wire [7:0] n1;
  integer err_count = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer k;
  reg [15:0] q;
  reg [15:0] p;
  cmit_timer dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
    .byte_en_in(be), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
    .match_irq_request_out(req), .irq_out(irq));
  cmit_intc_model intc_u (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req),
    .rise0_out(n0), .rise1_out(n1));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      test_done;
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rd(input [7:0] a, output [15:0] r);
    begin
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_in);
      rd_s <= 1'b0;
      @(negedge clk_in);
      r = rdata;
      @(posedge clk_in);
    end
  endtask
  task rc(input string nm, input [7:0] a, input [15:0] e);
    begin
      rd(a, q);
      chk(nm, e, q);
    end
  endtask
  // write followed at once by a read of the same place
  task wrrd(input [7:0] a, input [15:0] d, input [1:0] b, output [15:0] r);
    begin
      addr <= a;
      wdata <= d;
      be <= b;
      wr_s <= 1'b1;
      @(posedge clk_in);
      wr_s <= 1'b0;
      rd(a, r);
    end
  endtask
  // trailing edge keeps the strobe low for a cycle before the next request
  task wr(input [7:0] a, input [15:0] d, input [1:0] b);
    begin
      addr <= a;
      wdata <= d;
      be <= b;
      wr_s <= 1'b1;
      @(posedge clk_in);
      wr_s <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task t_reset;
    begin
      rc("cor0", 8'h06, 16'hFFFF);
      rc("cor1", 8'h0C, 16'hFFFF);
      rc("cnt0", 8'h04, 16'h0000);
      rc("csr1", 8'h08, 16'h0000);
      rc("run", 8'h00, 16'h0000);
      // read data stand for one cycle only, then the port falls back to zero
      rd(8'h06, q);
      @(negedge clk_in);
      chk("rdidle", 16'h0000, rdata);
      @(posedge clk_in);
      $display("done reset");
    end
  endtask
  // reads spaced one divisor apart must see exactly one step
  task t_taps;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wrrd(8'h08, k[15:0], 2'h3, q);
        chk("cks", k[15:0], q);
        wrrd(8'h00, 16'h0002, 2'h3, q);
        chk("run1", 16'h0002, q);
        rd(8'h0A, p);
        repeat ((8 << (2 * k)) - 2) @(posedge clk_in);
        rd(8'h0A, q);
        chk("step", 16'h0001, q - p);
      end
      wr(8'h00, 16'h0000, 2'h3);
      $display("done taps");
    end
  endtask
  task t_match;
    begin
      wrrd(8'h06, 16'h0002, 2'h3, q);
      wr(8'h02, 16'h0040, 2'h3);
      wr(8'h00, 16'h0001, 2'h3);
      k = 0;
      while (req[0] !== 1'b1 && k < 100) begin
        @(posedge clk_in);
        k = k + 1;
      end
      chk("req0", 16'h0001, {15'h0, req[0]});
      rc("flag0", 8'h02, 16'h00C0);
      rd(8'h04, p);
      repeat (6) @(posedge clk_in);
      rd(8'h04, q);
      chk("range", 16'h0001, {15'h0, q < 16'h0003});
      chk("wrap", (p == 16'h0002) ? 16'h0000 : p + 16'h0001, q);
      wr(8'h00, 16'h0000, 2'h3);
      chk("line0", 16'h0001, {8'h0, n0});
      chk("line1", 16'h0000, {8'h0, n1});
      $display("done match");
    end
  endtask
  task t_flag;
    begin
      wr(8'h02, 16'h00C0, 2'h1);
      wr(8'h02, 16'h0040, 2'h1);
      chk("unread", 16'h0001, {15'h0, req[0]});
      rc("kept", 8'h02, 16'h00C0);
      wr(8'h02, 16'h0040, 2'h1);
      chk("cleared", 16'h0000, {15'h0, req[0]});
      $display("done flag");
    end
  endtask
  task t_equal;
    begin
      wr(8'h04, 16'h0005, 2'h3);
      wr(8'h06, 16'h0005, 2'h3);
      rc("eqflag", 8'h02, 16'h00C0);
      rc("eqcnt", 8'h04, 16'h0000);
      wr(8'h12, 16'h0000, 2'h1);
      chk("masked", 16'h0000, {15'h0, irq});
      wr(8'h12, 16'h0001, 2'h1);
      chk("irq", 16'h0001, {15'h0, irq});
      wr(8'h10, 16'h0001, 2'h1);
      chk("irqclr", 16'h0000, {15'h0, irq});
      // second write lands in the match cycle of the first, so the clear wins
      addr <= 8'h04;
      wdata <= 16'h0005;
      be <= 2'h3;
      wr_s <= 1'b1;
      @(posedge clk_in);
      wdata <= 16'h0007;
      @(posedge clk_in);
      wr_s <= 1'b0;
      rd(8'h04, q);
      chk("clrwins", 16'h0000, q);
      $display("done equal");
    end
  endtask
  task t_byte;
    begin
      wr(8'h0A, 16'hAB12, 2'h3);
      wr(8'h0A, 16'h0034, 2'h1);
      rc("byte", 8'h0A, 16'hAB34);
      wrrd(8'h0C, 16'h1234, 2'h3, q);
      chk("cor1", 16'h1234, q);
      rc("hole", 8'h0E, 16'h0000);
      $display("done byte");
    end
  endtask
  // writes every third cycle meet every phase of the /8 tick
  task t_chan1;
    begin
      p = {8'h00, n0};
      wr(8'h08, 16'h0000, 2'h3);
      wr(8'h00, 16'h0002, 2'h3);
      for (k = 0; k < 8; k = k + 1) begin
        wrrd(8'h0A, 16'h2000 + k[15:0], 2'h3, q);
        chk("wordwr", 16'h2000 + k[15:0], q);
      end
      for (k = 0; k < 8; k = k + 1) begin
        wrrd(8'h0A, 16'h0040 + k[15:0], 2'h1, q);
        chk("bytewr", 16'h2040 + k[15:0], q);
      end
      wr(8'h00, 16'h0000, 2'h3);
      wr(8'h0A, 16'h0000, 2'h3);
      wr(8'h0C, 16'h0002, 2'h3);
      wr(8'h08, 16'h0040, 2'h3);
      wr(8'h00, 16'h0002, 2'h3);
      q = 16'h0000;
      k = 0;
      while (q != 16'h0002 && k < 40) begin
        rd(8'h0A, q);
        k = k + 1;
      end
      rc("noearly", 8'h08, 16'h0040);
      k = 0;
      while (req[1] !== 1'b1 && k < 100) begin
        @(posedge clk_in);
        k = k + 1;
      end
      @(negedge clk_in);
      chk("req1", 16'h0001, {15'h0, req[1]});
      chk("rise1", 16'h0001, {8'h0, n1});
      chk("rise0", p, {8'h0, n0});
      @(posedge clk_in);
      wr(8'h00, 16'h0000, 2'h3);
      rd(8'h08, q);
      chk("flag1", 16'h00C0, q);
      wr(8'h08, 16'h0040, 2'h1);
      chk("clr1", 16'h0000, {15'h0, req[1]});
      $display("done chan1");
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    t_reset;
    t_taps;
    t_match;
    t_flag;
    t_equal;
    t_byte;
    t_chan1;
    test_done;
  end
endmodule
